//--- rtl/anr_regs.sv
// negotiation register group behind the serial management pins
// assumes mdc and mdio inputs are synchronous to ref_clk_in and mdc phases span two or more cycles
// Summary of operation
// - advertisement bit 15 reads 0, read-only: primary page sent
// - advertisement bit 13 is writable, resets 0, offers remote-fault detection
// - advertisement bits 11 and 10 writable, reset 0: asymmetric and symmetric pause
// - advertisement bit 9 reads 0, read-only: four-pair mode not offered
// - advertisement bits 8 to 5 writable, reset 1: the four speed/duplex offers
// - advertisement selector bits 4:0 fixed read-only at 00001
// - partner register loads each received page, may be overwritten by later pages
// - partner bit 15 mirrors the partner's next-page bit, reset 0
// - partner bit 14 shows the partner's acknowledge, reset 0
// - partner bit 13 shows the partner's remote fault, reset 0
// - partner bits 11 and 10 show partner pause abilities, reset 0
// - partner bits 9, 8, 6 show partner four-pair, 100 full, 10 full
// - partner bit 7 set by 100 offer or 100 parallel detection
// - partner bit 5 set by 10 offer or 10 parallel detection
// - partner selector bits 4:0 hold the received selector, reset 00000
// - expansion bits 15:5 always read 0
// - expansion bit 4 shows a multiple link fault
// - expansion bit 3 shows partner next-page support
// - expansion bit 2 shows local ability to send further pages
// - expansion bit 1 set when a new page arrives
// - reading the partner register clears the page flag
// - expansion bit 0 shows the partner can negotiate
// - advertisement contents form the local word sent to the partner
`timescale 1ns/1ps
`default_nettype none
`include "anr_cfg.svh"
module anr_regs
    import anr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [4:0] dev_addr_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic page_stb_in,
    input wire logic [15:0] page_word_in,
    input wire logic pd_stb_in,
    input wire logic pd_fast_in,
    input wire anr_neg_status_t neg_status_in,
    output logic [15:0] adv_word_out
);
    anr_mgmt_state_t s_q;
    anr_mgmt_state_t s_d;
    logic mdc_rise;
    logic [15:0] sh_n;
    logic hdr_done;
    logic hdr_hit;
    logic hdr_rd;
    logic part_clr;
    logic wr_commit;
    logic [15:0] partner_word;
    logic page_rx;
    logic [15:0] exp_word;

    function automatic logic [15:0] read_word(input logic [4:0] a, input logic [15:0] adv,
                                              input logic [15:0] part, input logic [15:0] expw);
        logic [15:0] w;
        w = 16'h0000;
        case (a)
            `ANR_OFS_ADV: w = adv;
            `ANR_OFS_PART: w = part;
            `ANR_OFS_EXP: w = expw;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    anr_mdc_edge u_edge (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .mdc_in(mdc_in),
        .rise_out(mdc_rise)
    );

    anr_partner_cap u_part (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .page_stb_in(page_stb_in),
        .page_word_in(page_word_in),
        .pd_stb_in(pd_stb_in),
        .pd_fast_in(pd_fast_in),
        .clr_in(part_clr),
        .partner_out(partner_word),
        .page_rx_out(page_rx)
    );

    // expansion word assembled from registered status and the page flag
    assign exp_word = {`ANR_EXP_RSVD, s_q.stat.multi_fault_flag, s_q.stat.partner_extra_pages_able,
                       s_q.stat.local_extra_pages_able, page_rx, s_q.stat.partner_negotiates};

    // header bits: start 1, op 2, device address 5, register address 5
    assign sh_n = {s_q.sh[14:0], mdio_in};
    assign hdr_done = mdc_rise && (s_q.st == st_hdr) && (s_q.cnt == `ANR_HDR_LAST);
    assign hdr_hit = sh_n[12] && (sh_n[9:5] == dev_addr_in) &&
                     ((sh_n[11:10] == `ANR_OP_RD) || (sh_n[11:10] == `ANR_OP_WR));
    assign hdr_rd = (sh_n[11:10] == `ANR_OP_RD);
    assign part_clr = hdr_done && hdr_hit && hdr_rd && (sh_n[4:0] == `ANR_OFS_PART);
    assign wr_commit = mdc_rise && (s_q.st == st_wdat) && (s_q.cnt == `ANR_DATA_LAST) && s_q.hit &&
                       (s_q.reg_a == `ANR_OFS_ADV);

    always_comb begin
        s_d = s_q;
        s_d.stat = neg_status_in;
        case (s_q.st)
            st_idle: begin
                if (mdc_rise && !mdio_in) begin
                    s_d.st = st_hdr;
                    s_d.cnt = 4'h0;
                end
            end
            st_hdr: begin
                if (mdc_rise) begin
                    s_d.sh = sh_n;
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (hdr_done) begin
                        s_d.st = st_ta;
                        s_d.cnt = 4'h0;
                        s_d.hit = hdr_hit;
                        s_d.rd = hdr_rd;
                        s_d.reg_a = sh_n[4:0];
                        s_d.sh = read_word(sh_n[4:0], s_q.adv, partner_word, exp_word);
                    end
                end
            end
            st_ta: begin
                if (mdc_rise) begin
                    s_d.cnt = s_q.cnt + 4'h1;
                    if (s_q.rd && s_q.hit) begin
                        s_d.mdo_en = 1'b1;
                        s_d.mdo = (s_q.cnt == `ANR_TA_LAST) ? s_q.sh[15] : 1'b0;
                    end
                    if (s_q.cnt == `ANR_TA_LAST) begin
                        s_d.cnt = 4'h0;
                        s_d.st = s_q.rd ? st_rdat : st_wdat;
                    end
                end
            end
            st_rdat: begin
                if (mdc_rise) begin
                    s_d.cnt = s_q.cnt + 4'h1;
                    s_d.sh = {s_q.sh[14:0], 1'b0};
                    s_d.mdo = s_q.sh[14];
                    if (s_q.cnt == `ANR_DATA_LAST) begin
                        s_d.st = st_idle;
                        s_d.mdo = 1'b0;
                        s_d.mdo_en = 1'b0;
                    end
                end
            end
            st_wdat: begin
                if (mdc_rise) begin
                    s_d.cnt = s_q.cnt + 4'h1;
                    s_d.sh = sh_n;
                    if (s_q.cnt == `ANR_DATA_LAST) begin
                        s_d.st = st_idle;
                    end
                    if (wr_commit) begin
                        s_d.adv = (sh_n & `ANR_ADV_RW_MASK) | `ANR_ADV_FIXED;
                    end
                end
            end
            default: begin
                s_d.st = st_idle;
                s_d.mdo = 1'b0;
                s_d.mdo_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_q.st <= st_idle;
            s_q.cnt <= 4'h0;
            s_q.sh <= 16'h0000;
            s_q.rd <= 1'b0;
            s_q.hit <= 1'b0;
            s_q.reg_a <= 5'h00;
            s_q.adv <= `ANR_ADV_RESET;
            s_q.stat <= '0;
            s_q.mdo <= 1'b0;
            s_q.mdo_en <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign mdio_out = s_q.mdo;
    assign mdio_oe_out = s_q.mdo_en;
    assign adv_word_out = s_q.adv;

    // checks on the advertisement register
    adv_next_page_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (adv_word_out & `ANR_NP_MASK) == 16'h0000)
        else $error("advertised next-page bit not zero");

    adv_remote_fault_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_commit |=> ((adv_word_out & `ANR_RF_MASK) == ($past(sh_n) & `ANR_RF_MASK)))
        else $error("remote fault offer not taken from write");

    adv_pause_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_commit |=> ((adv_word_out & `ANR_PAUSE_MASK) == ($past(sh_n) & `ANR_PAUSE_MASK)))
        else $error("pause offers not taken from write");

    adv_four_pair_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (adv_word_out & `ANR_T4_MASK) == 16'h0000)
        else $error("four-pair offer not zero");

    adv_speed_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !wr_commit |=> $stable(adv_word_out & `ANR_SPEED_MASK))
        else $error("speed offers changed without a write");

    adv_selector_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (adv_word_out & `ANR_SEL_MASK) == `ANR_ADV_FIXED)
        else $error("selector not fixed");

    adv_reserved_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ((adv_word_out & `ANR_RSVD_MASK) == 16'h0000) && ((partner_word & ~`ANR_PART_MASK) == 16'h0000))
        else $error("reserved bit reads one");

    // checks on partner capture
    part_page_load_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        page_stb_in |=> (partner_word == ($past(page_word_in) & `ANR_PART_MASK)))
        else $error("partner word not loaded from page");

    part_fast_pd_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (pd_stb_in && pd_fast_in && !page_stb_in) |=> ((partner_word & `ANR_PART_FAST) != 16'h0000))
        else $error("100 parallel detect not shown");

    part_slow_pd_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (pd_stb_in && !pd_fast_in && !page_stb_in) |=> ((partner_word & `ANR_PART_SLOW) != 16'h0000))
        else $error("10 parallel detect not shown");

    // checks on the expansion word and the partner ability fields
    exp_reserved_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        exp_word[15:5] == `ANR_EXP_RSVD)
        else $error("expansion reserved bits not zero");

    exp_status_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ##1 (exp_word[4] == $past(neg_status_in.multi_fault_flag)) &&
            (exp_word[3] == $past(neg_status_in.partner_extra_pages_able)) &&
            (exp_word[2] == $past(neg_status_in.local_extra_pages_able)) &&
            (exp_word[0] == $past(neg_status_in.partner_negotiates)))
        else $error("expansion status lags its source");

    page_flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        page_stb_in |=> page_rx)
        else $error("page flag not set");

    page_flag_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (part_clr && !page_stb_in) |=> !page_rx)
        else $error("page flag survives partner read");

    page_flag_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (!part_clr && !page_stb_in) |=> (page_rx == $past(page_rx)))
        else $error("page flag changed without cause");

    page_set_wins_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (part_clr && page_stb_in) |=> page_rx)
        else $error("page flag lost to a same-cycle read");

    part_fields_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        page_stb_in |=> ((partner_word[15:13] == $past(page_word_in[15:13])) &&
            (partner_word[11:8] == $past(page_word_in[11:8])) && (partner_word[6] == $past(page_word_in[6]))))
        else $error("partner ability fields not copied from page");

    // main scenarios
    rd_partner_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) part_clr ##1 (s_q.st == st_ta));
    wr_adv_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) wr_commit);
    page_rx_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) page_stb_in ##1 page_rx);
    pd_fast_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) pd_stb_in && pd_fast_in);
    pd_slow_c: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) pd_stb_in && !pd_fast_in);
endmodule
`default_nettype wire

//--- include/anr_cfg.svh
// offsets, field masks, reset values and frame counts of the negotiation register group
// assumes a management frame with 5-bit device and register addresses
`ifndef ANR_CFG_SVH
`define ANR_CFG_SVH
`define ANR_OFS_ADV 5'h04
`define ANR_OFS_PART 5'h05
`define ANR_OFS_EXP 5'h06
`define ANR_ADV_RESET 16'h01e1
`define ANR_NP_MASK 16'h8000
`define ANR_RF_MASK 16'h2000
`define ANR_PAUSE_MASK 16'h0c00
`define ANR_T4_MASK 16'h0200
`define ANR_SPEED_MASK 16'h01e0
`define ANR_SEL_MASK 16'h001f
`define ANR_ADV_RW_MASK (`ANR_RF_MASK | `ANR_PAUSE_MASK | `ANR_SPEED_MASK)
`define ANR_ADV_FIXED 16'h0001
`define ANR_RSVD_MASK 16'h5000
`define ANR_PART_MASK 16'hefff
`define ANR_PART_RESET 16'h0000
`define ANR_PART_FAST 16'h0080
`define ANR_PART_SLOW 16'h0020
`define ANR_EXP_RSVD 11'h000
`define ANR_OP_RD 2'b10
`define ANR_OP_WR 2'b01
`define ANR_HDR_LAST 4'hc
`define ANR_TA_LAST 4'h1
`define ANR_DATA_LAST 4'hf
`endif

//--- include/anr_pkg.sv
// types shared by the negotiation register group
// assumes nothing beyond the cfg header for numbers
package anr_pkg;
    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_hdr = 5'h02,
        st_ta = 5'h04,
        st_rdat = 5'h08,
        st_wdat = 5'h10
    } anr_mdio_st_t;

    typedef struct packed {
        logic multi_fault_flag;
        logic partner_extra_pages_able;
        logic local_extra_pages_able;
        logic partner_negotiates;
    } anr_neg_status_t;

    typedef struct packed {
        anr_mdio_st_t st;
        logic [3:0] cnt;
        logic [15:0] sh;
        logic rd;
        logic hit;
        logic [4:0] reg_a;
        logic [15:0] adv;
        anr_neg_status_t stat;
        logic mdo;
        logic mdo_en;
    } anr_mgmt_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic page_rx;
    } anr_partner_state_t;

    typedef struct packed {
        logic mdc;
    } anr_edge_state_t;
endpackage

//--- rtl/anr_mdc_edge.sv
// rising-edge detector for the management clock pin
// assumes the pin is already synchronous to ref_clk_in
`timescale 1ns/1ps
`default_nettype none
module anr_mdc_edge
    import anr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic mdc_in,
    output logic rise_out
);
    anr_edge_state_t s_q;
    anr_edge_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.mdc = mdc_in;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rise_out = mdc_in & ~s_q.mdc;
endmodule
`default_nettype wire

//--- rtl/anr_partner_cap.sv
// partner ability word and page-received flag
// assumes page and parallel-detect strobes are one-cycle pulses from the negotiation engine
`timescale 1ns/1ps
`default_nettype none
`include "anr_cfg.svh"
module anr_partner_cap
    import anr_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic page_stb_in,
    input wire logic [15:0] page_word_in,
    input wire logic pd_stb_in,
    input wire logic pd_fast_in,
    input wire logic clr_in,
    output logic [15:0] partner_out,
    output logic page_rx_out
);
    anr_partner_state_t s_q;
    anr_partner_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (page_stb_in) begin
            s_d.word = page_word_in & `ANR_PART_MASK;
        end else if (pd_stb_in) begin
            s_d.word = s_q.word | (pd_fast_in ? `ANR_PART_FAST : `ANR_PART_SLOW);
        end
        if (page_stb_in) begin
            s_d.page_rx = 1'b1;
        end else if (clr_in) begin
            s_d.page_rx = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_q.word <= `ANR_PART_RESET;
            s_q.page_rx <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign partner_out = s_q.word;
    assign page_rx_out = s_q.page_rx;
endmodule
`default_nettype wire

//--- dv/anr_station.sv
// management station model: sends frames on the serial management pins
// assumes the bench resolves the mdio wire level, with a pull-up when nobody drives
`timescale 1ns/1ps
`default_nettype none
module anr_station (
    input wire logic ref_clk_in,
    input wire logic md_in,
    output logic mdc_out,
    output logic md_out,
    output logic md_oe_out
);
    initial begin
        mdc_out = 1'b0;
        md_out = 1'b0;
        md_oe_out = 1'b0;
    end

    // one mdc period: three cycles low, three high; the wire is sampled just before the rise
    task automatic bit_io(input logic d, input logic drv, output logic s);
        @(posedge ref_clk_in);
        mdc_out <= 1'b0;
        md_out <= d;
        md_oe_out <= drv;
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        s = md_in;
        @(posedge ref_clk_in);
        mdc_out <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
    endtask

    // whole frame; the pin is released for turnaround and data unless op is write
    task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [4:0] ra,
                         input logic [15:0] wd, output logic ta, output logic [15:0] rd);
        logic [13:0] hdr;
        logic drv;
        logic s;
        hdr = {2'b01, op, dev, ra};
        drv = (op == 2'b01);
        bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) begin
            bit_io(hdr[i], 1'b1, s);
        end
        bit_io(1'b1, drv, s);
        bit_io(1'b0, drv, s);
        ta = s;
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], drv, s);
            rd[i] = s;
        end
        // clock stands still low between frames
        @(posedge ref_clk_in);
        mdc_out <= 1'b0;
        md_oe_out <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the negotiation register group
// assumes the station model drives the management pins and the bench plays the negotiation engine
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import anr_pkg::*;
;
    localparam logic [4:0] DEV = 5'h03;
    logic ref_clk_in = 1'b0;
    logic rst_n_in;
    logic mdc;
    logic st_md;
    logic st_oe;
    logic mdio_out;
    logic mdio_oe_out;
    logic mdio_w;
    logic page_stb_in;
    logic pd_stb_in;
    logic pd_fast_in;
    logic [15:0] page_word_in;
    logic [15:0] adv_word_out;
    logic [4:0] dev_addr_in;
    anr_neg_status_t neg_status_in;
    int fails = 0;
    int check_count = 0;
    logic [15:0] adv_m;
    logic [15:0] part_m;
    logic [15:0] rd;
    logic [15:0] w;
    logic ta;

    always #5 ref_clk_in = ~ref_clk_in;
    assign mdio_w = mdio_oe_out ? mdio_out : (st_oe ? st_md : 1'b1);

    anr_regs u_dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .dev_addr_in(dev_addr_in), .mdc_in(mdc),
        .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .page_stb_in(page_stb_in),
        .page_word_in(page_word_in), .pd_stb_in(pd_stb_in), .pd_fast_in(pd_fast_in),
        .neg_status_in(neg_status_in), .adv_word_out(adv_word_out)
    );
    anr_station u_sta (
        .ref_clk_in(ref_clk_in), .md_in(mdio_w), .mdc_out(mdc), .md_out(st_md), .md_oe_out(st_oe)
    );

    function automatic logic [15:0] adv_f(input logic [15:0] v);
        return (v & 16'h2de0) | 16'h0001;
    endfunction

    function automatic logic [15:0] exp_f(input anr_neg_status_t s, input logic pg);
        return {11'h000, s.multi_fault_flag, s.partner_extra_pages_able, s.local_extra_pages_able,
                pg, s.partner_negotiates};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rd_reg(input logic [4:0] ra, output logic [15:0] v);
        u_sta.frame(2'b10, DEV, ra, 16'h0000, ta, v);
    endtask

    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] v);
        u_sta.frame(2'b01, DEV, ra, v, ta, rd);
    endtask

    task automatic page(input logic [15:0] v);
        @(posedge ref_clk_in);
        page_stb_in <= 1'b1;
        page_word_in <= v;
        @(posedge ref_clk_in);
        page_stb_in <= 1'b0;
        part_m = v & 16'hefff;
    endtask

    task automatic pd(input logic fast);
        @(posedge ref_clk_in);
        pd_stb_in <= 1'b1;
        pd_fast_in <= fast;
        @(posedge ref_clk_in);
        pd_stb_in <= 1'b0;
        part_m = part_m | (fast ? 16'h0080 : 16'h0020);
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk_in);
        fails++;
        tally_and_finish();
    end

    initial begin
        rst_n_in = 1'b0;
        page_stb_in = 1'b0;
        pd_stb_in = 1'b0;
        pd_fast_in = 1'b0;
        page_word_in = 16'h0000;
        dev_addr_in = DEV;
        neg_status_in = '0;
        void'($urandom(38));
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        adv_m = 16'h01e1;
        chk("adv_word_out reset", adv_m, adv_word_out);
        rd_reg(5'h04, rd);
        chk("adv reset", adv_m, rd);
        chk("turnaround", 16'h0000, {15'h0000, ta});
        rd_reg(5'h05, rd);
        chk("partner reset", 16'h0000, rd);
        rd_reg(5'h06, rd);
        chk("expansion reset", 16'h0000, rd);
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            wr_reg(5'h04, w);
            adv_m = adv_f(w);
            chk("adv_word_out", adv_m, adv_word_out);
            rd_reg(5'h04, rd);
            chk("adv readback", adv_m, rd);
        end
        wr_reg(5'h05, 16'hffff);
        wr_reg(5'h06, 16'hffff);
        u_sta.frame(2'b01, DEV ^ 5'h01, 5'h04, 16'h0000, ta, rd);
        for (int op = 0; op < 4; op += 3) begin
            u_sta.frame(2'(op), DEV, 5'h04, 16'h0000, ta, rd);
            chk("bad op wire", 16'hffff, rd);
        end
        u_sta.frame(2'b10, DEV ^ 5'h01, 5'h04, 16'h0000, ta, rd);
        chk("foreign device wire", 16'hffff, rd);
        rd_reg(5'h04, rd);
        chk("adv after refusals", adv_m, rd);
        rd_reg(5'h05, rd);
        chk("partner after write", 16'h0000, rd);
        rd_reg(5'h06, rd);
        chk("expansion after write", 16'h0000, rd);
        rd_reg(5'h07, rd);
        chk("unmapped read", 16'h0000, rd);
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            page(w);
            if (i == 1) page(16'($urandom));
            rd_reg(5'h06, rd);
            chk("page flag set", 16'h0002, rd & 16'h0002);
            rd_reg(5'h05, rd);
            chk("partner word", part_m, rd);
            rd_reg(5'h06, rd);
            chk("page flag cleared", 16'h0000, rd & 16'h0002);
        end
        page(16'h0001);
        for (int i = 1; i >= 0; i--) begin
            pd(i[0]);
            rd_reg(5'h05, rd);
            chk("parallel detect", part_m, rd);
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_in);
            neg_status_in <= anr_neg_status_t'(i[3:0]);
            rd_reg(5'h06, rd);
            chk("expansion", exp_f(anr_neg_status_t'(i[3:0]), 1'b0), rd);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
